// file: hw/rth_top.sv
// Room thermostat: sensor path, two-point hysteresis control, APB slave

// Function
// - Add a half-degree correction, limited to plus or minus five degrees.
// - Send sensor value periodically and when it moved by the set delta.
// - Answer sensor reads; refuse them while the sensor is disabled.
// - Take room temperature from own sensor or from the bus value.
// - Optionally use a weighted mean of both temperatures.
// - Compare measured temperature with active setpoint continuously.
// - Send the command object periodically or on change as configured.
// - Default heating: on below setpoint minus hysteresis, off at setpoint.
// - Default cooling: on above setpoint plus hysteresis, off below it.
// - Alternate heating: on below setpoint, off at setpoint plus hysteresis.
// - Alternate cooling: on above setpoint, off at setpoint minus hysteresis.
// - Separate hysteresis widths for heating and cooling.
// - Reversed hysteresis allowed only for floor or ceiling radiant panels.
// - One setpoint per operating mode, for heating and cooling each.
module rth_top #(
    parameter int TICK_CYC = rth_pkg::TICK_CYC
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire rth_pkg::rth_obj_t     sensor_in,
    input  wire rth_pkg::rth_obj_t     bus_temp_in,
    input  wire logic                  season_cool,
    input  wire logic                  rd_req,
    output rth_pkg::rth_obj_t          rd_rsp,
    output logic                       rd_unavail,
    output rth_pkg::rth_obj_t          sensor_tx,
    output rth_pkg::rth_cmd_obj_t      cmd_tx
);
    logic [31:0] ctrl_ff, nxt_ctrl, hyst_ff, nxt_hyst;
    logic [31:0] txcfg_ff, nxt_txcfg, cmdper_ff, nxt_cmdper;
    logic [15:0] sp_ff [rth_pkg::NSP];
    logic [15:0] nxt_sp [rth_pkg::NSP];
    logic [31:0] prdata_ff, nxt_prdata;
    logic        pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
    logic        wr_en, mapped;
    logic [31:0] rd_mux;

    // APB: answer registered in setup, so one access cycle always
    assign wr_en = psel && penable && pready_ff && pwrite;
    assign mapped = (paddr[1:0] == 2'b00) && (paddr <= rth_pkg::A_SENS);

    always_comb begin
        nxt_ctrl   = ctrl_ff;
        nxt_hyst   = hyst_ff;
        nxt_txcfg  = txcfg_ff;
        nxt_cmdper = cmdper_ff;
        nxt_sp     = sp_ff;
        if (wr_en && mapped) begin
            if (paddr == rth_pkg::A_CTRL) begin
                nxt_ctrl = {12'h000, pwdata[19:0]};
            end else if (paddr == rth_pkg::A_HYST) begin
                nxt_hyst = pwdata;
            end else if (paddr == rth_pkg::A_TXCFG) begin
                nxt_txcfg = pwdata;
            end else if (paddr == rth_pkg::A_CMDPER) begin
                nxt_cmdper = {16'h0000, pwdata[15:0]};
            end else if (paddr >= rth_pkg::A_SP0
                         && paddr <= rth_pkg::A_SP7) begin
                nxt_sp[3'(paddr[7:2] - 6'h04)] = pwdata[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff   <= rth_pkg::CTRL_RST;
            hyst_ff   <= rth_pkg::HYST_RST;
            txcfg_ff  <= rth_pkg::TXCFG_RST;
            cmdper_ff <= rth_pkg::CMDPER_RST;
            for (int i = 0; i < rth_pkg::NSP; i++) begin
                sp_ff[i] <= (i < 4) ? rth_pkg::SP_H_RST : rth_pkg::SP_C_RST;
            end
        end else begin
            ctrl_ff   <= nxt_ctrl;
            hyst_ff   <= nxt_hyst;
            txcfg_ff  <= nxt_txcfg;
            cmdper_ff <= nxt_cmdper;
            sp_ff     <= nxt_sp;
        end
    end

    // Configuration fields
    logic                 sen_en, heat_en, cool_en, alt_sel, per_sel;
    rth_pkg::rth_src_t    src;
    rth_pkg::rth_term_t   term;
    logic [1:0]           mode;
    logic signed [4:0]    off_raw, off_c;
    logic [3:0]           wgt;
    assign sen_en  = ctrl_ff[rth_pkg::C_SEN];
    assign heat_en = ctrl_ff[rth_pkg::C_HEAT];
    assign cool_en = ctrl_ff[rth_pkg::C_COOL];
    assign alt_sel = ctrl_ff[rth_pkg::C_ALT];
    assign per_sel = ctrl_ff[rth_pkg::C_PER];
    assign src     = rth_pkg::rth_src_t'(ctrl_ff[rth_pkg::C_SRC +: 2]);
    assign term    = rth_pkg::rth_term_t'(ctrl_ff[rth_pkg::C_TERM +: 2]);
    assign mode    = ctrl_ff[rth_pkg::C_MODE +: 2];
    assign off_raw = $signed(ctrl_ff[rth_pkg::C_OFF +: 5]);
    assign wgt     = ctrl_ff[rth_pkg::C_WGT +: 4];

    // Inputs captured; the seen flags keep stale zero out of control
    logic signed [15:0] raw_ff, nxt_raw, btemp_ff, nxt_btemp;
    logic               raw_ok_ff, nxt_raw_ok, b_ok_ff, nxt_b_ok;
    always_comb begin
        nxt_raw    = sensor_in.valid ? sensor_in.value : raw_ff;
        nxt_raw_ok = raw_ok_ff || sensor_in.valid;
        nxt_btemp  = bus_temp_in.valid ? bus_temp_in.value : btemp_ff;
        nxt_b_ok   = b_ok_ff || bus_temp_in.valid;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_ff    <= 16'sh0000;
            raw_ok_ff <= 1'b0;
            btemp_ff  <= 16'sh0000;
            b_ok_ff   <= 1'b0;
        end else begin
            raw_ff    <= nxt_raw;
            raw_ok_ff <= nxt_raw_ok;
            btemp_ff  <= nxt_btemp;
            b_ok_ff   <= nxt_b_ok;
        end
    end

    // Corrected sensor and measured temperature
    logic signed [15:0] sens_cor, t_meas;
    logic signed [16:0] cor_sum;
    logic signed [21:0] mean_acc;
    logic               sens_ok, temp_ok;
    always_comb begin
        off_c = off_raw;
        if (off_raw > rth_pkg::OFF_MAX) begin
            off_c = rth_pkg::OFF_MAX;
        end else if (off_raw < -rth_pkg::OFF_MAX) begin
            off_c = -rth_pkg::OFF_MAX;
        end
        cor_sum  = 17'(raw_ff)
                 + 17'(off_c) * 17'(rth_pkg::HALF_DEG);
        sens_cor = cor_sum[15:0];
        mean_acc = 22'(sens_cor) * 22'(wgt)
                 + 22'(btemp_ff) * 22'(rth_pkg::WGT_FULL - {2'b00, wgt});
        sens_ok  = sen_en && raw_ok_ff;
        if (src == rth_pkg::RTH_SRC_BUS) begin
            t_meas  = btemp_ff;
            temp_ok = b_ok_ff;
        end else if (src == rth_pkg::RTH_SRC_MEAN) begin
            t_meas  = mean_acc[19:4];
            temp_ok = sens_ok && b_ok_ff;
        end else begin
            t_meas  = sens_cor;
            temp_ok = sens_ok;
        end
    end

    // Tick prescaler; the interval timers count in ticks
    logic [31:0] pre_ff, nxt_pre;
    logic        tick;
    assign tick = (pre_ff == 32'(TICK_CYC - 1));
    assign nxt_pre = tick ? 32'h0000_0000 : pre_ff + 32'h0000_0001;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_ff <= 32'h0000_0000;
        end else begin
            pre_ff <= nxt_pre;
        end
    end

    // Hysteresis controller
    logic               cooling, active, alt_ok, on_c, off_c_t;
    logic signed [16:0] t17, sp17, hh17, hc17;
    rth_pkg::rth_cmd_st_t cmd_st_ff, nxt_cmd;
    // Season object only matters when both actions are enabled
    assign cooling = (heat_en && cool_en) ? season_cool : cool_en;
    assign active  = heat_en || cool_en;
    assign alt_ok  = alt_sel && (term == rth_pkg::RTH_TERM_FLOOR
                              || term == rth_pkg::RTH_TERM_CEIL);
    assign t17  = 17'(t_meas);
    assign sp17 = 17'($signed(sp_ff[{cooling, mode}]));
    assign hh17 = {1'b0, hyst_ff[15:0]};
    assign hc17 = {1'b0, hyst_ff[31:16]};

    always_comb begin
        if (!cooling) begin
            on_c    = alt_ok ? (t17 < sp17) : (t17 < sp17 - hh17);
            off_c_t = alt_ok ? (t17 >= sp17 + hh17) : (t17 >= sp17);
        end else begin
            on_c    = alt_ok ? (t17 > sp17) : (t17 > sp17 + hc17);
            off_c_t = alt_ok ? (t17 <= sp17 - hc17) : (t17 < sp17);
        end
        nxt_cmd = cmd_st_ff;
        if (!active) begin
            nxt_cmd = rth_pkg::RTH_CMD_OFF;
        end else if (temp_ok) begin
            case (cmd_st_ff)
                rth_pkg::RTH_CMD_OFF: if (on_c) nxt_cmd = rth_pkg::RTH_CMD_ON;
                rth_pkg::RTH_CMD_ON: if (off_c_t) nxt_cmd = rth_pkg::RTH_CMD_OFF;
                default: nxt_cmd = rth_pkg::RTH_CMD_OFF;
            endcase
        end
    end

    // Transmit timers and object outputs
    logic               s_exp, c_exp, delta_hit, s_send, c_send;
    logic signed [16:0] s_diff;
    logic signed [15:0] last_tx_ff, nxt_last_tx;
    rth_pkg::rth_obj_t     stx_ff, nxt_stx, rsp_ff, nxt_rsp;
    rth_pkg::rth_cmd_obj_t ctx_ff, nxt_ctx;
    logic                  unav_ff, nxt_unav;

    rth_timer u_sens_tmr (
        .clk     (pclk),
        .rst_n   (presetn),
        .tick    (tick),
        .restart (s_send),
        .period  (txcfg_ff[15:0]),
        .expire  (s_exp)
    );
    rth_timer u_cmd_tmr (
        .clk     (pclk),
        .rst_n   (presetn),
        .tick    (tick),
        .restart (!per_sel),
        .period  (cmdper_ff[15:0]),
        .expire  (c_exp)
    );

    always_comb begin
        s_diff    = 17'(sens_cor) - 17'(last_tx_ff);
        delta_hit = (txcfg_ff[31:16] != 16'h0000)
                 && ((s_diff < 0 ? -s_diff : s_diff)
                     >= $signed({1'b0, txcfg_ff[31:16]}));
        s_send    = sens_ok && (s_exp || delta_hit);
        nxt_stx   = '{valid: s_send, value: sens_cor};
        nxt_last_tx = s_send ? sens_cor : last_tx_ff;
        c_send  = per_sel ? c_exp : (nxt_cmd != cmd_st_ff);
        nxt_ctx = '{valid: c_send, on: nxt_cmd == rth_pkg::RTH_CMD_ON};
        nxt_rsp  = '{valid: rd_req && sens_ok, value: sens_cor};
        nxt_unav = rd_req && !sens_ok;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_st_ff  <= rth_pkg::RTH_CMD_OFF;
            last_tx_ff <= 16'sh0000;
            stx_ff     <= '0;
            ctx_ff     <= '0;
            rsp_ff     <= '0;
            unav_ff    <= 1'b0;
        end else begin
            cmd_st_ff  <= nxt_cmd;
            last_tx_ff <= nxt_last_tx;
            stx_ff     <= nxt_stx;
            ctx_ff     <= nxt_ctx;
            rsp_ff     <= nxt_rsp;
            unav_ff    <= nxt_unav;
        end
    end

    // APB read data and answer
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (paddr == rth_pkg::A_CTRL) begin
            rd_mux = ctrl_ff;
        end else if (paddr == rth_pkg::A_HYST) begin
            rd_mux = hyst_ff;
        end else if (paddr == rth_pkg::A_TXCFG) begin
            rd_mux = txcfg_ff;
        end else if (paddr == rth_pkg::A_CMDPER) begin
            rd_mux = cmdper_ff;
        end else if (paddr >= rth_pkg::A_SP0 && paddr <= rth_pkg::A_SP7) begin
            rd_mux = {16'h0000, sp_ff[3'(paddr[7:2] - 6'h04)]};
        end else if (paddr == rth_pkg::A_STAT) begin
            rd_mux = {13'h0000, temp_ok, cooling, cmd_st_ff, t_meas};
        end else if (paddr == rth_pkg::A_SENS) begin
            rd_mux = {16'h0000, sens_cor};
        end
        nxt_pready  = psel && !penable;
        nxt_prdata  = (nxt_pready && !pwrite && mapped) ? rd_mux : prdata_ff;
        nxt_pslverr = nxt_pready && !mapped;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign prdata     = prdata_ff;
    assign pready     = pready_ff;
    assign pslverr    = pslverr_ff;
    assign rd_rsp     = rsp_ff;
    assign rd_unavail = unav_ff;
    assign sensor_tx  = stx_ff;
    assign cmd_tx     = ctx_ff;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence apb_setup_s;
        psel && !penable;
    endsequence
    sequence apb_done_s;
        pready ##1 !pready;
    endsequence
    sequence flip_s;
        nxt_cmd != cmd_st_ff;
    endsequence

    apb_answer_a: assert property (apb_setup_s |=> apb_done_s)
        else $error("apb answer not one cycle");
    read_value_a: assert property (
        rd_req && sens_ok |=> rd_rsp.valid && rd_rsp.value == $past(sens_cor))
        else $error("sensor read answer wrong");
    read_refuse_a: assert property (
        rd_req && !sens_ok |=> rd_unavail && !rd_rsp.valid)
        else $error("disabled sensor read answered");
    sens_send_a: assert property (
        sens_ok && (s_exp || delta_hit) |=> sensor_tx.valid ##1 !s_exp)
        else $error("sensor value not sent");
    heat_on_a: assert property (
        active && !cooling && !alt_ok && temp_ok && t17 < sp17 - hh17
        |=> cmd_st_ff == rth_pkg::RTH_CMD_ON)
        else $error("heating not switched on");
    cool_on_a: assert property (
        active && cooling && !alt_ok && temp_ok && t17 > sp17 + hc17
        |=> cmd_st_ff == rth_pkg::RTH_CMD_ON)
        else $error("cooling not switched on");
    alt_heat_a: assert property (
        active && !cooling && alt_ok && temp_ok && t17 >= sp17 + hh17
        |=> cmd_st_ff == rth_pkg::RTH_CMD_OFF)
        else $error("alternate heating not off");
    alt_cool_a: assert property (
        active && cooling && alt_ok && temp_ok && t17 <= sp17 - hc17
        |=> cmd_st_ff == rth_pkg::RTH_CMD_OFF)
        else $error("alternate cooling not off");
    cmd_hold_a: assert property (
        active && temp_ok && !on_c && !off_c_t |=> $stable(cmd_st_ff))
        else $error("command moved inside band");
    event_send_a: assert property (
        !per_sel and flip_s |=> cmd_tx.valid
        && cmd_tx.on == (cmd_st_ff == rth_pkg::RTH_CMD_ON))
        else $error("command change not sent");
    alt_gate_a: assert property (
        term != rth_pkg::RTH_TERM_FLOOR && term != rth_pkg::RTH_TERM_CEIL
        |-> !alt_ok)
        else $error("reversed hysteresis on wrong terminal");
endmodule

// file: hw/rth_pkg.sv
// Shared constants, register map and carrier types of the room thermostat
package rth_pkg;
    // Timing: one control tick per second at a 20 ns clock
    localparam int CLK_NS   = 20;
    localparam int TICK_MS  = 1000;
    localparam int TICK_CYC = TICK_MS * 1000000 / CLK_NS;

    // Register byte addresses
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_HYST   = 8'h04;
    localparam logic [7:0] A_TXCFG  = 8'h08;
    localparam logic [7:0] A_CMDPER = 8'h0C;
    localparam logic [7:0] A_SP0    = 8'h10;
    localparam logic [7:0] A_SP7    = 8'h2C;
    localparam logic [7:0] A_STAT   = 8'h30;
    localparam logic [7:0] A_SENS   = 8'h34;
    localparam int         NSP      = 8;

    // Control field positions
    localparam int C_SEN   = 0;
    localparam int C_SRC   = 1;
    localparam int C_HEAT  = 3;
    localparam int C_COOL  = 4;
    localparam int C_ALT   = 5;
    localparam int C_TERM  = 6;
    localparam int C_MODE  = 8;
    localparam int C_PER   = 10;
    localparam int C_OFF   = 11;
    localparam int C_WGT   = 16;
    // Status field positions
    localparam int S_ON    = 16;
    localparam int S_COOL  = 17;
    localparam int S_OK    = 18;

    // Reset values (temperatures in 0.01 degC)
    localparam logic [31:0] CTRL_RST   = 32'h0008_0009;
    localparam logic [31:0] HYST_RST   = 32'h0032_0032;
    localparam logic [31:0] TXCFG_RST  = 32'h0032_003C;
    localparam logic [31:0] CMDPER_RST = 32'h0000_003C;
    localparam logic [15:0] SP_H_RST   = 16'h07D0;
    localparam logic [15:0] SP_C_RST   = 16'h0960;

    // Correction step of half a degree, limit of ten steps
    localparam logic signed [7:0] HALF_DEG = 8'sh32;
    localparam logic signed [4:0] OFF_MAX  = 5'sh0A;
    localparam logic [5:0]        WGT_FULL = 6'h10;

    typedef enum logic [1:0] {
        RTH_SRC_INT  = 2'b00,
        RTH_SRC_BUS  = 2'b01,
        RTH_SRC_MEAN = 2'b10,
        RTH_SRC_RSV  = 2'b11
    } rth_src_t;

    typedef enum logic [1:0] {
        RTH_TERM_RAD   = 2'b00,
        RTH_TERM_FAN   = 2'b01,
        RTH_TERM_FLOOR = 2'b10,
        RTH_TERM_CEIL  = 2'b11
    } rth_term_t;

    typedef enum logic {
        RTH_CMD_OFF = 1'b0,
        RTH_CMD_ON  = 1'b1
    } rth_cmd_st_t;

    typedef struct packed {
        logic               valid;
        logic signed [15:0] value;
    } rth_obj_t;

    typedef struct packed {
        logic valid;
        logic on;
    } rth_cmd_obj_t;
endpackage

// file: hw/rth_timer.sv
// Repeating interval timer counted in control ticks
module rth_timer (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        tick,
    input  wire logic        restart,
    input  wire logic [15:0] period,
    output logic             expire
);
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic        exp_ff;
    logic        nxt_exp;

    // A period of zero disables the timer
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_exp = 1'b0;
        if (restart || period == 16'h0000) begin
            nxt_cnt = 16'h0000;
        end else if (tick) begin
            if (cnt_ff + 16'h0001 >= period) begin
                nxt_cnt = 16'h0000;
                nxt_exp = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 16'h0000;
            exp_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            exp_ff <= nxt_exp;
        end
    end

    assign expire = exp_ff;
endmodule

// file: verif/rth_actuator.sv
// Behavioural actuator and sensor listener on the far side of the bus
module rth_actuator (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire rth_pkg::rth_cmd_obj_t cmd_rx,
    input  wire rth_pkg::rth_obj_t     temp_rx,
    output logic                       act_on,
    output int                         n_cmd,
    output int                         n_temp
);
    timeunit 1ns;
    timeprecision 1ps;

    // Relay follows every frame, so periodic repeats are counted too
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_on <= 1'b0;
            n_cmd  <= 0;
            n_temp <= 0;
        end else begin
            if (cmd_rx.valid) begin
                act_on <= cmd_rx.on;
                n_cmd  <= n_cmd + 1;
            end
            if (temp_rx.valid)
                n_temp <= n_temp + 1;
        end
    end
endmodule

// file: verif/tb_top.sv
// Self-checking bench: APB tasks and directed thermostat scenarios
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TCYC = 10;
    logic                  pclk;
    logic                  presetn;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [7:0]            paddr;
    logic [31:0]           pwdata;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    rth_pkg::rth_obj_t     sensor_in;
    rth_pkg::rth_obj_t     bus_temp_in;
    logic                  season_cool;
    logic                  rd_req;
    rth_pkg::rth_obj_t     rd_rsp;
    logic                  rd_unavail;
    rth_pkg::rth_obj_t     sensor_tx;
    rth_pkg::rth_cmd_obj_t cmd_tx;
    logic                  act_on;
    int                    n_cmd;
    int                    n_temp;
    int                    fail_count;
    int                    n_checks;
    int                    k;
    int                    j;
    int                    c0;
    int                    c1;
    logic [31:0]           q;
    logic                  err;

    logic [7:0]  ra [6] = '{rth_pkg::A_CTRL, rth_pkg::A_HYST, rth_pkg::A_TXCFG,
        rth_pkg::A_CMDPER, rth_pkg::A_SP0, rth_pkg::A_SP7};
    logic [31:0] rv [6] = '{rth_pkg::CTRL_RST, rth_pkg::HYST_RST,
        rth_pkg::TXCFG_RST, rth_pkg::CMDPER_RST, {16'h0000, rth_pkg::SP_H_RST},
        {16'h0000, rth_pkg::SP_C_RST}};
    logic [4:0]  offs [4] = '{5'h03, 5'h1F, 5'h0F, 5'h11};
    logic [15:0] soff [4] = '{16'h0866, 16'h079E, 16'h09C4, 16'h05DC};
    logic [31:0] rctl [8] = '{32'h0008_0009, 32'h0008_0011, 32'h0008_00A9,
        32'h0008_00F1, 32'h0008_0029, 32'h0008_0109, 32'h0008_0019,
        32'h0008_000B};
    logic [15:0] rt [8][5] = '{
        '{16'h07D0, 16'h07A8, 16'h079D, 16'h07CF, 16'h07D0},
        '{16'h0960, 16'h09A6, 16'h09A7, 16'h0960, 16'h095F},
        '{16'h0802, 16'h07D0, 16'h07CF, 16'h0801, 16'h0802},
        '{16'h091A, 16'h0960, 16'h0961, 16'h091B, 16'h091A},
        '{16'h07D0, 16'h07CF, 16'h079D, 16'h07CF, 16'h07D0},
        '{16'h09C4, 16'h099C, 16'h0991, 16'h09C3, 16'h09C4},
        '{16'h095F, 16'h09A6, 16'h09A7, 16'h0960, 16'h095F},
        '{16'h07D0, 16'h07A8, 16'h079D, 16'h07CF, 16'h07D0}};
    // Every row walks off, hold off, on, hold on, off
    logic [4:0]  pat = 5'h0C;

    rth_top #(.TICK_CYC(TCYC)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sensor_in(sensor_in), .bus_temp_in(bus_temp_in),
        .season_cool(season_cool), .rd_req(rd_req), .rd_rsp(rd_rsp),
        .rd_unavail(rd_unavail), .sensor_tx(sensor_tx), .cmd_tx(cmd_tx));
    rth_actuator act_u (.pclk(pclk), .presetn(presetn), .cmd_rx(cmd_tx),
        .temp_rx(sensor_tx), .act_on(act_on), .n_cmd(n_cmd),
        .n_temp(n_temp));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Idle edge, so a following call never drives psel twice at once
        @(posedge pclk);
    endtask

    task automatic feed(input logic bus, input logic [15:0] v);
        @(posedge pclk);
        if (bus)
            bus_temp_in <= '{1'b1, v};
        else
            sensor_in <= '{1'b1, v};
        @(posedge pclk);
        bus_temp_in <= '{1'b0, ~v};
        sensor_in   <= '{1'b0, ~v};
        repeat (5) @(posedge pclk);
    endtask

    task automatic sreq(input logic ok, input logic [15:0] v);
        @(posedge pclk);
        rd_req <= 1'b1;
        @(posedge pclk);
        rd_req <= 1'b0;
        @(negedge pclk);
        chk({30'h0, rd_rsp.valid, rd_unavail}, {30'h0, ok, !ok});
        if (ok)
            chk({16'h0000, rd_rsp.value}, {16'h0000, v});
        @(posedge pclk);
    endtask

    initial begin
        {presetn, psel, penable, pwrite, season_cool, rd_req} = 6'h00;
        {paddr, pwdata, fail_count, n_checks} = '0;
        sensor_in   = '{1'b0, 16'h0000};
        bus_temp_in = '{1'b0, 16'h0000};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (k = 0; k < 6; k++) begin
            apb(1'b0, ra[k], 32'h0);
            chk(q, rv[k]);
        end
        apb(1'b0, 8'h38, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("register defaults done");
        for (k = 0; k < 4; k++) begin
            apb(1'b1, rth_pkg::A_CTRL,
                rth_pkg::CTRL_RST | (32'(offs[k]) << rth_pkg::C_OFF));
            feed(1'b0, 16'h07D0);
            apb(1'b0, rth_pkg::A_SENS, 32'h0);
            chk({16'h0000, q[15:0]}, {16'h0000, soff[k]});
        end
        sreq(1'b1, 16'h05DC);
        apb(1'b1, rth_pkg::A_CTRL, 32'h0008_0008);
        sreq(1'b0, 16'h0000);
        $display("sensor correction and reads done");
        apb(1'b1, rth_pkg::A_HYST, 32'h0046_0032);
        apb(1'b1, rth_pkg::A_SP0 + 8'h04, 32'h0000_09C4);
        c0 = n_cmd;
        for (k = 0; k < 8; k++) begin
            season_cool <= (k == 6);
            apb(1'b1, rth_pkg::A_CTRL, rctl[k]);
            for (j = 0; j < 5; j++) begin
                feed(k == 7, rt[k][j]);
                chk(32'(act_on), 32'(pat[j]));
            end
        end
        // Row 0 also switches off at the mode write; rows 5 and 6 switch on there and off again at the first feed
        chk(n_cmd - c0, 32'd21);
        season_cool <= 1'b0;
        $display("hysteresis control done");
        apb(1'b1, rth_pkg::A_CTRL, 32'h0004_000D);
        feed(1'b0, 16'h0708);
        feed(1'b1, 16'h0898);
        apb(1'b0, rth_pkg::A_STAT, 32'h0);
        chk({16'h0000, q[15:0]}, 32'h0000_0834);
        apb(1'b1, rth_pkg::A_TXCFG, 32'h0064_0000);
        feed(1'b0, 16'h03E8);
        c1 = n_temp;
        feed(1'b0, 16'h044B);
        chk(n_temp - c1, 32'd0);
        feed(1'b0, 16'h044C);
        chk(n_temp - c1, 32'd1);
        $display("mean and delta send done");
        apb(1'b1, rth_pkg::A_CMDPER, 32'h0000_0002);
        apb(1'b1, rth_pkg::A_TXCFG, 32'h0000_0003);
        apb(1'b1, rth_pkg::A_CTRL, 32'h0008_0409);
        c0 = n_cmd;
        c1 = n_temp;
        repeat (300) @(posedge pclk);
        chk({31'h0, (n_cmd - c0) inside {[14:16]}}, 32'h1);
        chk({31'h0, (n_temp - c1) inside {[9:11]}}, 32'h1);
        $display("periodic send done");
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_of_test();
    end
endmodule
